// >>> rtl/nfh_defines.vh
`ifndef NFH_DEFINES_VH
`define NFH_DEFINES_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define NFH_CMD_RESET    8'hFF
`define NFH_CMD_READID   8'h90
`define NFH_CMD_READ1    8'h00
`define NFH_CMD_READ2    8'h30
`define NFH_CMD_PROG1    8'h80
`define NFH_CMD_PROG2    8'h10
`define NFH_CMD_ERASE1   8'h60
`define NFH_CMD_ERASE2   8'hD0
`define NFH_CMD_STATUS   8'h70
`define NFH_ID_ADDR      8'h00

// ----------------------------------------
// User operation codes
// ----------------------------------------
`define NFH_OP_RESET     3'h0
`define NFH_OP_READID    3'h1
`define NFH_OP_READ      3'h2
`define NFH_OP_PROG      3'h3
`define NFH_OP_ERASE     3'h4
`define NFH_OP_STATUS    3'h5

// ----------------------------------------
// Geometry
// ----------------------------------------
`define NFH_COL_BITS     13
`define NFH_PAGE_BITS    6
`define NFH_BLOCK_BITS   13
`define NFH_ROW_BITS     19
`define NFH_PAGE_MAIN    2048
`define NFH_PAGE_SPARE   128
`define NFH_PLANE_BIT    6
`define NFH_ID_BYTES     13'h0005
`define NFH_ADDR_FIRST   3'h0
`define NFH_ADDR_LAST    3'h4
`define NFH_ROW_FIRST    3'h2
`define NFH_FIFO_WIDTH   8
`define NFH_FIFO_DEPTH   16
`define NFH_FIFO_AW      4

// ----------------------------------------
// Timing
// ----------------------------------------
`define NFH_CLK_MHZ      40
`define NFH_PHASE_NS     50
`define NFH_PHASE_CYC    ((`NFH_PHASE_NS * `NFH_CLK_MHZ + 999) / 1000)
`define NFH_TWB_NS       100
`define NFH_TWB_TICKS    ((`NFH_TWB_NS + `NFH_PHASE_NS - 1) / `NFH_PHASE_NS)

`endif

// >>> rtl/nfh_fifo.v
`timescale 1ns/1ps
// ----------------------------------------
// Synchronous FIFO
// ----------------------------------------
module nfh_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wptr_reg;
   reg [AW:0]      rptr_reg;
   wire            push;
   wire            pop;

   // Extra pointer bit tells full from empty
   assign in_ready  = (wptr_reg[AW] == rptr_reg[AW]) || (wptr_reg[AW-1:0] != rptr_reg[AW-1:0]);
   assign out_valid = (wptr_reg != rptr_reg);
   assign out_data  = mem[rptr_reg[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage has no reset, it is never read while empty
   always @(posedge clk) begin
      if (push) begin
         mem[wptr_reg[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_reg <= {(AW+1){1'b0}};
         rptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wptr_reg <= wptr_reg + {{AW{1'b0}}, 1'b1};
         end
         if (pop) begin
            rptr_reg <= rptr_reg + {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // nfh_fifo

// >>> rtl/nfh_host.v
`timescale 1ns/1ps
`include "nfh_defines.vh"
// ----------------------------------------
// NAND flash pin-level host sequencer
// ----------------------------------------
module nfh_host (
   input  wire        clk,
   input  wire        rst_n,
   // User command port
   input  wire        cmd_valid,
   output wire        cmd_ready,
   input  wire [2:0]  cmd_op,
   input  wire [12:0] cmd_col,
   input  wire [18:0] cmd_row,
   input  wire [12:0] cmd_len,
   output reg         cmd_done,
   output wire        init_done,
   // User controls
   input  wire        write_allow,
   input  wire        protect_request,
   // Program data in
   input  wire        wr_valid,
   output wire        wr_ready,
   input  wire [7:0]  wr_data,
   // Read data out
   output reg         rd_valid,
   output reg  [7:0]  rd_data,
   // Flash pins
   output reg         nand_ce_n,
   output reg         nand_cle,
   output reg         nand_ale,
   output reg         nand_we_n,
   output reg         read_strobe_n,
   output reg         nand_wp_n,
   output reg         volatile_protect_enable_in,
   input  wire        nand_rb_n,
   input  wire [7:0]  shared_bus_in,
   output reg  [7:0]  shared_bus_out,
   output reg         shared_bus_oe
);
   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam S_IDLE  = 3'h0;
   localparam S_CMD1  = 3'h1;
   localparam S_ADDR  = 3'h2;
   localparam S_WDATA = 3'h3;
   localparam S_CMD2  = 3'h4;
   localparam S_BUSY  = 3'h5;
   localparam S_RDATA = 3'h6;
   localparam S_DONE  = 3'h7;

   reg [2:0]  state_reg;
   reg [1:0]  ph_reg;
   reg [3:0]  div_reg;
   reg [3:0]  wb_reg;
   reg [2:0]  op_reg;
   reg [12:0] col_reg;
   reg [18:0] row_reg;
   reg [12:0] len_reg;
   reg [12:0] cnt_reg;
   reg [2:0]  aidx_reg;
   reg        init_reg;
   wire       tick;
   wire       fifo_valid;
   wire [7:0] fifo_data;
   wire       fifo_pop;
   wire       cmd_phase;

   // ----------------------------------------
   // Address byte mapping
   // ----------------------------------------
   function [7:0] addr_byte;
      input [2:0]  idx;
      input [12:0] col;
      input [18:0] row;
      begin
         case (idx)
            3'h0:    addr_byte = col[7:0];
            3'h1:    addr_byte = {3'h0, col[12:8]};
            3'h2:    addr_byte = row[7:0];
            3'h3:    addr_byte = row[15:8];
            3'h4:    addr_byte = {5'h00, row[18:16]};
            default: addr_byte = 8'h00;
         endcase
      end
   endfunction

   // First and second command of each operation
   function [7:0] op_cmd;
      input [2:0] op;
      input       second;
      begin
         case (op)
            `NFH_OP_RESET:  op_cmd = `NFH_CMD_RESET;
            `NFH_OP_READID: op_cmd = `NFH_CMD_READID;
            `NFH_OP_READ:   op_cmd = second ? `NFH_CMD_READ2 : `NFH_CMD_READ1;
            `NFH_OP_PROG:   op_cmd = second ? `NFH_CMD_PROG2 : `NFH_CMD_PROG1;
            `NFH_OP_ERASE:  op_cmd = second ? `NFH_CMD_ERASE2 : `NFH_CMD_ERASE1;
            default:        op_cmd = `NFH_CMD_STATUS;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Phase divider and handshakes
   // ----------------------------------------
   // Only reset is accepted until the first reset completes
   assign cmd_ready = (state_reg == S_IDLE) && (init_reg || cmd_op == `NFH_OP_RESET);
   assign init_done = init_reg;
   assign tick      = (div_reg == `NFH_PHASE_CYC - 1);
   assign fifo_pop  = tick && (state_reg == S_WDATA) && (ph_reg == 2'h2);
   assign cmd_phase = (state_reg == S_CMD1) || (state_reg == S_CMD2);

   // Each pin phase lasts one divider period
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 4'h0;
      end else if (tick) begin
         div_reg <= 4'h0;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end

   // Program data buffer, back-pressure reaches wr_ready
   nfh_fifo #(
      .WIDTH (`NFH_FIFO_WIDTH),
      .DEPTH (`NFH_FIFO_DEPTH),
      .AW    (`NFH_FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // Static protect pins follow user levels through flops
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nand_wp_n                  <= 1'b0;
         volatile_protect_enable_in <= 1'b0;
      end else begin
         nand_wp_n                  <= write_allow;
         volatile_protect_enable_in <= protect_request;
      end
   end

   // ----------------------------------------
   // Pin sequencer
   // ----------------------------------------
   // Phase 0 sets latches and data, 1 drops strobe, 2 raises it;
   // latches move at phase 0, or clear a clock after the last rise, so they hold past the rising edge.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= S_IDLE;
         ph_reg         <= 2'h0;
         wb_reg         <= 4'h0;
         op_reg         <= 3'h0;
         col_reg        <= 13'h0000;
         row_reg        <= 19'h00000;
         len_reg        <= 13'h0000;
         cnt_reg        <= 13'h0000;
         aidx_reg       <= 3'h0;
         init_reg       <= 1'b0;
         cmd_done       <= 1'b0;
         rd_valid       <= 1'b0;
         rd_data        <= 8'h00;
         nand_ce_n      <= 1'b1;
         nand_cle       <= 1'b0;
         nand_ale       <= 1'b0;
         nand_we_n      <= 1'b1;
         read_strobe_n  <= 1'b1;
         shared_bus_out <= 8'h00;
         shared_bus_oe  <= 1'b0;
      end else begin
         cmd_done <= 1'b0;
         rd_valid <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (cmd_valid && cmd_ready) begin
                  op_reg    <= cmd_op;
                  col_reg   <= (cmd_op == `NFH_OP_READID) ? 13'h0000 : cmd_col;
                  row_reg   <= cmd_row;
                  len_reg   <= (cmd_op == `NFH_OP_READID) ? `NFH_ID_BYTES :
                               (cmd_op == `NFH_OP_STATUS) ? 13'h0001 : cmd_len;
                  aidx_reg  <= (cmd_op == `NFH_OP_ERASE) ? `NFH_ROW_FIRST : `NFH_ADDR_FIRST;
                  cnt_reg   <= 13'h0000;
                  ph_reg    <= 2'h0;
                  nand_ce_n <= 1'b0;
                  state_reg <= S_CMD1;
               end
            end
            S_CMD1, S_CMD2, S_ADDR, S_WDATA: begin
               if (tick) begin
                  case (ph_reg)
                     2'h0: begin
                        // Never both latches high at once
                        nand_cle      <= cmd_phase;
                        nand_ale      <= (state_reg == S_ADDR);
                        shared_bus_oe <= 1'b1;
                        if (state_reg == S_ADDR) begin
                           // READID sends col byte 0, which is forced to 00h
                           shared_bus_out <= addr_byte(aidx_reg, col_reg, row_reg);
                        end else if (state_reg == S_WDATA) begin
                           shared_bus_out <= fifo_data;
                        end else begin
                           shared_bus_out <= op_cmd(op_reg, state_reg == S_CMD2);
                        end
                        // Data phase stalls until the buffer has a byte
                        if (state_reg != S_WDATA || fifo_valid) begin
                           ph_reg <= 2'h1;
                        end
                     end
                     2'h1: begin
                        nand_we_n <= 1'b0;
                        ph_reg    <= 2'h2;
                     end
                     default: begin
                        nand_we_n <= 1'b1;
                        ph_reg    <= 2'h0;
                        wb_reg    <= 4'h0;
                        cnt_reg   <= 13'h0000;
                        case (state_reg)
                           S_CMD1: begin
                              if (op_reg == `NFH_OP_RESET) begin
                                 state_reg <= S_BUSY;
                              end else if (op_reg == `NFH_OP_STATUS) begin
                                 state_reg <= S_RDATA;
                              end else begin
                                 state_reg <= S_ADDR;
                              end
                           end
                           S_ADDR: begin
                              aidx_reg <= aidx_reg + 3'h1;
                              if (op_reg == `NFH_OP_READID) begin
                                 state_reg <= S_RDATA;
                              end else if (aidx_reg != `NFH_ADDR_LAST) begin
                                 state_reg <= S_ADDR;
                              end else if (op_reg == `NFH_OP_PROG && len_reg != 13'h0000) begin
                                 state_reg <= S_WDATA;
                              end else begin
                                 state_reg <= S_CMD2;
                              end
                           end
                           S_WDATA: begin
                              cnt_reg <= cnt_reg + 13'h0001;
                              if (cnt_reg + 13'h0001 == len_reg) begin
                                 state_reg <= S_CMD2;
                              end
                           end
                           default: state_reg <= S_BUSY;
                        endcase
                     end
                  endcase
               end
            end
            S_BUSY: begin
               // Wait out the busy assert delay, then poll the pulled-up line
               nand_cle      <= 1'b0;
               nand_ale      <= 1'b0;
               shared_bus_oe <= 1'b0;
               if (tick) begin
                  if (wb_reg != `NFH_TWB_TICKS) begin
                     wb_reg <= wb_reg + 4'h1;
                  end else if (nand_rb_n) begin
                     ph_reg    <= 2'h0;
                     state_reg <= (op_reg == `NFH_OP_READ) ? S_RDATA : S_DONE;
                  end
               end
            end
            S_RDATA: begin
               // Bus released so the device may drive it
               nand_cle      <= 1'b0;
               nand_ale      <= 1'b0;
               shared_bus_oe <= 1'b0;
               if (tick) begin
                  case (ph_reg)
                     2'h0: begin
                        if (len_reg == 13'h0000) begin
                           state_reg <= S_DONE;
                        end else begin
                           ph_reg <= 2'h1;
                        end
                     end
                     2'h1: begin
                        read_strobe_n <= 1'b0;
                        ph_reg        <= 2'h2;
                     end
                     default: begin
                        // Sampled a full phase after the fall
                        read_strobe_n <= 1'b1;
                        rd_data       <= shared_bus_in;
                        rd_valid      <= 1'b1;
                        ph_reg        <= 2'h0;
                        cnt_reg       <= cnt_reg + 13'h0001;
                        if (cnt_reg + 13'h0001 == len_reg) begin
                           state_reg <= S_DONE;
                        end
                     end
                  endcase
               end
            end
            default: begin
               nand_ce_n     <= 1'b1;
               nand_cle      <= 1'b0;
               nand_ale      <= 1'b0;
               shared_bus_oe <= 1'b0;
               cmd_done      <= 1'b1;
               if (op_reg == `NFH_OP_RESET) begin
                  init_reg <= 1'b1;
               end
               state_reg <= S_IDLE;
            end
         endcase
      end
   end
endmodule // nfh_host

// >>> dv/nfh_flash_model.sv
`timescale 1ns/1ps
// ----------
// NAND device model
// ----------
module nfh_flash_model #(
   parameter        BUSY_NS = 400,
   parameter [39:0] ID_SEQ  = 40'h5A3C001122  // Arbitrary identity bytes
) (
   input  wire       ce_n,
   input  wire       cle,
   input  wire       ale,
   input  wire       we_n,
   input  wire       rd_stb_n,
   input  wire       wp_n,
   input  wire [7:0] bus,
   output reg        rb_n = 1'b1,
   output reg  [7:0] dq = 8'hFF
);
   reg [7:0]  mem [0:2175];
   reg [7:0]  cmd;
   reg [7:0]  first_cmd;
   reg [7:0]  last = 8'h00;
   reg [2:0]  acnt;
   reg [12:0] col;
   reg [12:0] col_start;
   reg [18:0] row;
   reg        plane;
   reg        die;
   reg [10:0] pblock;
   reg        below_lockout = 1'b0;  // Supply under lockout_voltage
   integer    cmd_cnt = 0;
   integer    erases = 0;
   event      busy_ev;
   // Open drain with pull-up: low only while working
   always @(busy_ev) begin
      rb_n = 1'b0;
      #(BUSY_NS) rb_n = 1'b1;
   end
   // Bytes land on the strobe rise of a selected, ready device
   always @(posedge we_n) begin
      if (!ce_n && rb_n && !below_lockout) begin
         if (cle) begin
            cmd = bus;
            cmd_cnt = cmd_cnt + 1;
            if (cmd_cnt == 1)
               first_cmd = bus;
            acnt = (bus == 8'h60) ? 3'h2 : 3'h0;
            if (bus == 8'h90)
               col = 13'h0000;
            if (bus == 8'hFF || bus == 8'h30)
               -> busy_ev;
            if ((bus == 8'h10 || bus == 8'hD0) && wp_n) begin
               erases = erases + (bus == 8'hD0);
               -> busy_ev;
            end
         end else if (ale) begin
            case (acnt)
               3'h0: col[7:0] = bus;
               3'h1: col[12:8] = bus[4:0];
               3'h2: row[7:0] = bus;
               3'h3: row[15:8] = bus;
               default: row[18:16] = bus[2:0];
            endcase
            acnt = acnt + 3'h1;
            col_start = col;
            plane = row[6];
            pblock = row[17:7];
            die = row[18];
         end else if (wp_n) begin
            mem[col] = bus;
            col = col + 13'h1;
         end
      end
   end
   // Byte follows the read strobe fall after an access delay
   always @(negedge rd_stb_n) begin
      if (!ce_n) begin
         #10;
         last = (cmd == 8'h90) ? ID_SEQ[39 - 8 * col[2:0] -: 8] :
                (cmd == 8'h70) ? {wp_n, 7'h40} : mem[col];
         dq = last;
         col = col + 13'h1;
      end
   end
   // Released lines drift so a late sample never sees old data
   always @(posedge rd_stb_n or posedge ce_n) begin
      #5;
      dq = ~last;
   end
endmodule  // nfh_flash_model

// >>> dv/nfh_host_sva.sv
`timescale 1ns/1ps
`include "nfh_defines.vh"
// ----------
// Pin protocol checker
// ----------
module nfh_host_sva (
   input logic       clk,
   input logic       rst_n,
   input logic       cmd_ready,
   input logic [2:0] cmd_op,
   input logic       cmd_done,
   input logic       init_done,
   input logic       write_allow,
   input logic       protect_request,
   input logic       rd_valid,
   input logic       nand_ce_n,
   input logic       nand_cle,
   input logic       nand_ale,
   input logic       nand_we_n,
   input logic       read_strobe_n,
   input logic       nand_wp_n,
   input logic       volatile_protect_enable_in,
   input logic       nand_rb_n,
   input logic [7:0] shared_bus_out,
   input logic       shared_bus_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic seen_reg;
   // Marks the first command byte since reset
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         seen_reg <= 1'b0;
      else if ($rose(nand_we_n) && nand_cle)
         seen_reg <= 1'b1;
   end
   sequence we_low_hold;
      (!nand_we_n && shared_bus_oe && $stable({nand_cle, nand_ale, shared_bus_out}))[*2];
   endsequence
   sequence rd_low_hold;
      (!read_strobe_n && !shared_bus_oe && !nand_ce_n)[*2];
   endsequence
   latch_excl_a: assert property (!(nand_cle && nand_ale))
      else $error("both latches high");
   we_pulse_a: assert property ($fell(nand_we_n) |-> we_low_hold ##1 nand_we_n)
      else $error("write strobe shape");
   rd_pulse_a: assert property (
      $fell(read_strobe_n) |-> rd_low_hold ##1 (read_strobe_n && rd_valid))
      else $error("read strobe shape");
   strobe_sel_a: assert property (nand_ce_n |-> nand_we_n && read_strobe_n)
      else $error("strobe while deselected");
   busy_quiet_a: assert property (!nand_rb_n |-> nand_we_n && read_strobe_n)
      else $error("strobe while busy");
   init_gate_a: assert property (!init_done && cmd_ready |-> cmd_op == `NFH_OP_RESET)
      else $error("op taken before init");
   first_reset_a: assert property (
      $rose(nand_we_n) && nand_cle && !seen_reg |-> shared_bus_out == `NFH_CMD_RESET)
      else $error("first command not reset");
   wp_follow_a: assert property (
      (write_allow[*2] |-> nand_wp_n) and (!write_allow[*2] |-> !nand_wp_n))
      else $error("protect pin wrong");
   prot_follow_a: assert property (
      (protect_request[*2] |-> volatile_protect_enable_in) and
      (!protect_request[*2] |-> !volatile_protect_enable_in))
      else $error("protect enable wrong");
   done_pulse_a: assert property (cmd_done |-> nand_ce_n ##1 !cmd_done)
      else $error("done pulse wrong");
endmodule  // nfh_host_sva
bind nfh_host nfh_host_sva i_nfh_host_sva (.clk, .rst_n, .cmd_ready, .cmd_op, .cmd_done,
   .init_done, .write_allow, .protect_request, .rd_valid, .nand_ce_n, .nand_cle, .nand_ale,
   .nand_we_n, .read_strobe_n, .nand_wp_n, .volatile_protect_enable_in, .nand_rb_n,
   .shared_bus_out, .shared_bus_oe);

// >>> dv/testbench.sv
`timescale 1ns/1ps
`include "nfh_defines.vh"
module testbench;
   localparam [39:0] ID_SEQ = 40'h5A3C001122;  // Arbitrary identity bytes
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cmd_valid = 1'b0;
   logic [2:0]  cmd_op = 3'h0;
   logic [12:0] cmd_col = 13'h0000;
   logic [12:0] cmd_len = 13'h0000;
   logic [18:0] cmd_row = 19'h00000;
   logic        write_allow = 1'b0;
   logic        protect_request = 1'b0;
   logic        wr_valid = 1'b0;
   logic [7:0]  wr_data = 8'h00;
   wire         cmd_ready, cmd_done, init_done, wr_ready, rd_valid, nand_rb_n, shared_bus_oe;
   wire         nand_ce_n, nand_cle, nand_ale, nand_we_n, read_strobe_n, nand_wp_n;
   wire         volatile_protect_enable_in;
   wire [7:0]   rd_data, shared_bus_out, dq;
   wire [7:0]   bus_w = shared_bus_oe ? shared_bus_out : dq;  // Resolved pin level
   int          fail_count = 0;
   int          comparisons = 0;
   int          cycles = 0;
   logic [7:0]  rdq[$];
   nfh_host i_nfh_host (.clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_col, .cmd_row,
      .cmd_len, .cmd_done, .init_done, .write_allow, .protect_request, .wr_valid, .wr_ready,
      .wr_data, .rd_valid, .rd_data, .nand_ce_n, .nand_cle, .nand_ale, .nand_we_n,
      .read_strobe_n, .nand_wp_n, .volatile_protect_enable_in, .nand_rb_n,
      .shared_bus_in(bus_w), .shared_bus_out, .shared_bus_oe);
   nfh_flash_model #(.ID_SEQ(ID_SEQ)) i_model (.ce_n(nand_ce_n), .cle(nand_cle),
      .ale(nand_ale), .we_n(nand_we_n), .rd_stb_n(read_strobe_n), .wp_n(nand_wp_n),
      .bus(bus_w), .rb_n(nand_rb_n), .dq(dq));
   // ----------
   // Clock, capture and hang guard
   // ----------
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (rd_valid === 1'b1)
         rdq.push_back(rd_data);
      cycles++;
      if (cycles == 20000) begin  // Run needs well under a thousand
         fail_count++;
         close_out();
      end
   end
   task close_out;
      if (fail_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task check(input logic [39:0] seen, input logic [39:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // One user operation, held until taken, then wait for its end
   task run_op(input logic [2:0] op, input logic [12:0] col, input logic [18:0] row,
               input logic [12:0] len);
      @(posedge clk);
      #1;
      cmd_op = op;
      cmd_col = col;
      cmd_row = row;
      cmd_len = len;
      cmd_valid = 1'b1;
      do @(posedge clk); while (cmd_ready !== 1'b1);
      #1 cmd_valid = 1'b0;
      do @(posedge clk); while (cmd_done !== 1'b1);
      repeat (3) @(posedge clk);
   endtask
   // ----------
   // Scenarios
   // ----------
   task t_init;
      @(posedge clk);
      #1 cmd_op = `NFH_OP_READID;
      cmd_valid = 1'b1;
      repeat (4) @(posedge clk);
      check(cmd_ready, 1'b0, "early ready");
      check(i_model.cmd_cnt, 0, "early commands");
      #1 cmd_valid = 1'b0;
      run_op(`NFH_OP_RESET, 13'h0000, 19'h00000, 13'h0000);
      check(init_done, 1'b1, "init done");
      check(i_model.first_cmd, `NFH_CMD_RESET, "first command");
   endtask
   task t_readid;
      rdq.delete();
      run_op(`NFH_OP_READID, 13'h0000, 19'h00000, 13'h0005);
      check(rdq.size(), 5, "id count");
      check(i_model.col_start, 13'h0000, "id address");
      for (int i = 0; i < 5; i++)
         check(rdq[i], ID_SEQ[39 - 8 * i -: 8], "id byte");
   endtask
   // Fill buffer until refused, program into spare area, read back
   task t_prog_read;
      int n;
      n = 0;
      @(posedge clk);
      #1 write_allow = 1'b1;
      wr_valid = 1'b1;
      wr_data = 8'hA0;
      while (n < 20) begin
         @(posedge clk);
         if (wr_ready !== 1'b1)
            break;
         n++;
         #1 wr_data = 8'hA0 + n[7:0];
      end
      #1 wr_valid = 1'b0;
      check(n, 16, "buffer fill");
      run_op(`NFH_OP_PROG, 13'h0800, 19'h000C5, 13'h0010);
      check(i_model.row, 19'h000C5, "row address");
      check(i_model.col_start, 13'h0800, "col address");
      check(i_model.plane, 1'b1, "plane");
      check(i_model.pblock, 11'h001, "plane block");
      check(i_model.die, 1'b0, "die low");
      check(i_model.mem[2063], 8'hAF, "spare byte");
      check(wr_ready, 1'b1, "buffer drained");
      rdq.delete();
      run_op(`NFH_OP_READ, 13'h0800, 19'h000C5, 13'h0010);
      check(rdq.size(), 16, "read count");
      for (int i = 0; i < 16; i++)
         check(rdq[i], 8'hA0 + i[7:0], "read byte");
   endtask
   // Protected erase refused, status shows it, then allowed
   task t_protect;
      int e;
      e = i_model.erases;
      @(posedge clk);
      #1 write_allow = 1'b0;
      protect_request = 1'b1;
      repeat (2) @(posedge clk);
      check(nand_wp_n, 1'b0, "protect pin");
      check(volatile_protect_enable_in, 1'b1, "protect enable");
      run_op(`NFH_OP_ERASE, 13'h0000, 19'h400C0, 13'h0000);
      check(i_model.erases, e, "erase refused");
      check(i_model.die, 1'b1, "die high");
      rdq.delete();
      run_op(`NFH_OP_STATUS, 13'h0000, 19'h00000, 13'h0001);
      check(rdq[0], 8'h40, "status");
      #1 write_allow = 1'b1;
      i_model.below_lockout = 1'b1;
      run_op(`NFH_OP_ERASE, 13'h0000, 19'h400C0, 13'h0000);
      check(i_model.erases, e, "lockout erase");
      i_model.below_lockout = 1'b0;
      run_op(`NFH_OP_ERASE, 13'h0000, 19'h400C0, 13'h0000);
      check(i_model.erases, e + 1, "erase done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      t_init();
      t_readid();
      t_prog_read();
      t_protect();
      close_out();
   end
endmodule  // testbench
